// file: hw/mifd_pkg.sv
// package for the instruction field decoder: field positions, opcodes, types
// assumes a 14-bit instruction word fetched by the surrounding core
package mifd_pkg;
  localparam int INSN_W      = 14;
  localparam int FILE_W      = 7;
  localparam int BITN_W      = 3;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int DEST_POS    = 7;
  localparam int FILE_LSB    = 0;
  localparam int BITN_LSB    = 7;
  localparam int LIT_LSB     = 0;
  localparam int CAT_LSB     = 12;
  localparam int BOP_LSB     = 10;
  localparam int OP4_LSB     = 8;
  localparam int PHASES      = 4;
  localparam logic [1:0] CAT_BYTE = 2'h0;
  localparam logic [1:0] CAT_BIT  = 2'h1;
  localparam logic [1:0] CAT_JUMP = 2'h2;
  localparam logic [1:0] CAT_LIT  = 2'h3;
  localparam logic [3:0] OP_DECFSZ = 4'hb;
  localparam logic [3:0] OP_INCFSZ = 4'hf;
  localparam logic [1:0] BOP_TSTC  = 2'h2;
  localparam logic [1:0] BOP_TSTS  = 2'h3;
  localparam logic [13:0] INSN_RET    = 14'h0008;
  localparam logic [13:0] INSN_RETFIE = 14'h0009;
  localparam logic [3:0] OP_RETLW_HI  = 4'h4;
  localparam logic [1:0] RETLW_MASK   = 2'h3;
  localparam logic [13:0] INSN_NO_OPERATION = 14'h0000;

  typedef enum logic [1:0] {
    MIFD_CLASS_BYTE = 2'b00,
    MIFD_CLASS_BIT  = 2'b01,
    MIFD_CLASS_LIT  = 2'b10
  } mifd_class_t;

  typedef struct packed {
    mifd_class_t        cls;
    logic               dest_file;
    logic [FILE_W-1:0]  file_addr;
    logic [BITN_W-1:0]  bit_num;
    logic [LIT8_W-1:0]  lit8;
    logic [LIT11_W-1:0] lit11;
    logic               is_skip;
    logic               is_branch;
  } mifd_fields_t;
endpackage

// file: hw/mifd_decoder.sv
// instruction field decoder with four-phase instruction cycle sequencer
// assumes the core presents a new word when insn_take_o pulses and reports
// the outcome of a conditional test by the last phase of the cycle
//
// Operation
// - accept one 14-bit word: opcode plus operands
// - dest bit 0 to accumulator, 1 to file
// - file address is seven bits, 0x00-0x7f
// - bit number picks one of eight bits
// - literal is eight bits, eleven for jumps
// - don't-care bits never change decoded operation
// - classify byte, bit, or literal/control
// - normal instructions finish in one cycle
// - taken skip or branch adds no-operation cycle
// - instruction cycle is four oscillator periods
`timescale 1ns/1ps
module mifd_decoder #(
  parameter int PHASE_CNT = mifd_pkg::PHASES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic [mifd_pkg::INSN_W-1:0] insn_i,
  input  wire logic                        test_true_i,
  output mifd_pkg::mifd_fields_t           fields_o,
  output logic      [1:0]                  phase_o,
  output logic                             insn_take_o,
  output logic                             exec_o,
  output logic                             flush_o
);
  import mifd_pkg::*;

  // elaboration check: the two-bit phase counter and its wrap serve exactly four phases
  if (PHASE_CNT != 4) begin : g_bad_phase_cnt
    $error("phase counter serves four phases only");
  end

  typedef enum logic [0:0] {
    MIFD_ST_EXEC  = 1'b0,
    MIFD_ST_FLUSH = 1'b1
  } mifd_state_t;

  // field extraction; positions fixed, so don't-care bits never reach a decision
  wire logic [1:0]         cat     = insn_i[CAT_LSB +: 2];
  wire logic [3:0]         op4     = insn_i[OP4_LSB +: 4];
  wire logic [1:0]         bop     = insn_i[BOP_LSB +: 2];
  wire logic               dest_w  = insn_i[DEST_POS];
  wire logic [FILE_W-1:0]  faddr   = insn_i[FILE_LSB +: FILE_W];
  wire logic [BITN_W-1:0]  bitn    = insn_i[BITN_LSB +: BITN_W];
  wire logic [LIT8_W-1:0]  lit8    = insn_i[LIT_LSB +: LIT8_W];
  wire logic [LIT11_W-1:0] lit11   = insn_i[LIT_LSB +: LIT11_W];

  // skip candidates: conditional tests that may drop the next word
  wire logic is_skip_byte = (cat == CAT_BYTE) && ((op4 == OP_DECFSZ) || (op4 == OP_INCFSZ));
  wire logic is_skip_bit  = (cat == CAT_BIT) && ((bop == BOP_TSTC) || (bop == BOP_TSTS));
  // program counter writers: jumps, returns; retlw ignores its low op bits
  wire logic is_retlw  = (cat == CAT_LIT) && ((op4 & ~{2'h0, RETLW_MASK}) == OP_RETLW_HI);
  wire logic is_branch = (cat == CAT_JUMP) || (insn_i == INSN_RET)
                         || (insn_i == INSN_RETFIE) || is_retlw;
  wire mifd_class_t cls_d = (cat == CAT_BYTE) ? MIFD_CLASS_BYTE
                          : (cat == CAT_BIT)  ? MIFD_CLASS_BIT
                          : MIFD_CLASS_LIT;

  mifd_state_t  state_reg, state_next;
  logic [1:0]   phase_reg;
  mifd_fields_t fields_reg, fields_next;

  wire logic last_phase = (phase_reg == 2'(PHASE_CNT - 1));
  wire logic first_phase = (phase_reg == 2'h0);
  // a skip only costs a cycle when its test came out true
  wire logic extra_cycle = fields_reg.is_branch || (fields_reg.is_skip && test_true_i);

  // next state: the extra cycle is only decided on the last phase, once the test is known
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MIFD_ST_EXEC: begin
        if (last_phase && extra_cycle) begin
          state_next = MIFD_ST_FLUSH;
        end else if (last_phase) begin
          state_next = MIFD_ST_EXEC;
        end
      end
      MIFD_ST_FLUSH: begin
        if (last_phase) begin
          state_next = MIFD_ST_EXEC;
        end
      end
    endcase
  end

  // capture decoded fields at the start of each execute cycle
  always_comb begin
    fields_next = fields_reg;
    if (first_phase && state_reg == MIFD_ST_EXEC) begin
      fields_next.cls       = cls_d;
      fields_next.dest_file = (cat == CAT_BYTE) ? dest_w : 1'b0;
      fields_next.file_addr = faddr;
      fields_next.bit_num   = bitn;
      fields_next.lit8      = lit8;
      fields_next.lit11     = lit11;
      fields_next.is_skip   = is_skip_byte || is_skip_bit;
      fields_next.is_branch = is_branch;
    end else if (first_phase) begin
      fields_next           = '0; // flush cycle carries a no-operation
      fields_next.cls       = MIFD_CLASS_BYTE;
    end
  end

  // four oscillator periods per instruction cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= last_phase ? 2'h0 : phase_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg  <= MIFD_ST_EXEC;
      fields_reg <= '0;
    end else begin
      state_reg  <= state_next;
      fields_reg <= fields_next;
    end
  end

  assign insn_take_o = first_phase && (state_reg == MIFD_ST_EXEC);
  assign exec_o      = (state_reg == MIFD_ST_EXEC);
  assign flush_o     = (state_reg == MIFD_ST_FLUSH);
  assign phase_o     = phase_reg;
  assign fields_o    = fields_reg;

  // assertions
  property p_phase_wrap;
    @(posedge clk_i) disable iff (!rstn_i)
      (phase_reg == 2'h3) |=> (phase_reg == 2'h0) ##3 (phase_reg == 2'h3);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("cycle not four phases");

  property p_flush_len;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(flush_o) |-> flush_o [*4] ##1 !flush_o;
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("flush not one cycle");

  property p_branch_flush;
    @(posedge clk_i) disable iff (!rstn_i)
      (exec_o && last_phase && fields_reg.is_branch) |=> flush_o;
  endproperty
  a_branch_flush: assert property (p_branch_flush) else $error("branch lacked flush");

  property p_single;
    @(posedge clk_i) disable iff (!rstn_i)
      (exec_o && last_phase && !fields_reg.is_branch && !(fields_reg.is_skip && test_true_i))
      |=> insn_take_o;
  endproperty
  a_single: assert property (p_single) else $error("plain insn took two cycles");

  property p_dest;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && cat == CAT_BYTE) |=> (fields_o.dest_file == $past(insn_i[DEST_POS]));
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_faddr;
    @(posedge clk_i) disable iff (!rstn_i)
      insn_take_o |=> (fields_o.file_addr == $past(insn_i[6:0]));
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address wrong");

  property p_bitn;
    @(posedge clk_i) disable iff (!rstn_i)
      insn_take_o |=> (fields_o.bit_num == $past(insn_i[9:7]));
  endproperty
  a_bitn: assert property (p_bitn) else $error("bit number wrong");

  property p_lit;
    @(posedge clk_i) disable iff (!rstn_i)
      insn_take_o |=> (fields_o.lit8 == $past(insn_i[7:0]))
                      && (fields_o.lit11 == $past(insn_i[10:0]));
  endproperty
  a_lit: assert property (p_lit) else $error("literal wrong");

  property p_class;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:12] == 2'h1) |=> (fields_o.cls == MIFD_CLASS_BIT);
  endproperty
  a_class: assert property (p_class) else $error("category wrong");

  property p_flush_nop;
    @(posedge clk_i) disable iff (!rstn_i)
      (flush_o && phase_reg == 2'h1) |-> (!fields_o.is_branch && !fields_o.is_skip);
  endproperty
  a_flush_nop: assert property (p_flush_nop) else $error("flush not a no-operation");

  // classification follows the category bits alone
  property p_class_byte;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:12] == 2'h0) |=> (fields_o.cls == MIFD_CLASS_BYTE);
  endproperty
  a_class_byte: assert property (p_class_byte) else $error("byte category wrong");

  property p_class_lit;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13]) |=> (fields_o.cls == MIFD_CLASS_LIT);
  endproperty
  a_class_lit: assert property (p_class_lit) else $error("literal category wrong");

  // only byte operations may steer a result back into the file
  property p_dest_other;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:12] != 2'h0) |=> !fields_o.dest_file;
  endproperty
  a_dest_other: assert property (p_dest_other) else $error("destination set off byte op");

  // skip candidates must be flagged so the test outcome can cost a cycle
  property p_skip_byte;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:12] == 2'h0 && (insn_i[11:8] == 4'hb || insn_i[11:8] == 4'hf))
      |=> fields_o.is_skip;
  endproperty
  a_skip_byte: assert property (p_skip_byte) else $error("byte skip not flagged");

  property p_skip_bit;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:12] == 2'h1) |=> (fields_o.is_skip == $past(insn_i[11]));
  endproperty
  a_skip_bit: assert property (p_skip_bit) else $error("bit skip flag wrong");

  // program counter writers
  property p_jump_branch;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:12] == 2'h2) |=> fields_o.is_branch;
  endproperty
  a_jump_branch: assert property (p_jump_branch) else $error("jump not flagged");

  property p_return_branch;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && (insn_i == 14'h0008 || insn_i == 14'h0009)) |=> fields_o.is_branch;
  endproperty
  a_return_branch: assert property (p_return_branch) else $error("return not flagged");

  // don't-care bits in the literal group must not move the decision either way
  property p_retlw_dc;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:10] == 4'hd) |=> fields_o.is_branch;
  endproperty
  a_retlw_dc: assert property (p_retlw_dc) else $error("literal return depends on x bits");

  property p_movlw_dc;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:10] == 4'hc) |=> (!fields_o.is_branch && !fields_o.is_skip);
  endproperty
  a_movlw_dc: assert property (p_movlw_dc) else $error("literal move depends on x bits");

  property p_addlw_dc;
    @(posedge clk_i) disable iff (!rstn_i)
      (insn_take_o && insn_i[13:9] == 5'h1f)
      |=> (fields_o.cls == MIFD_CLASS_LIT && !fields_o.is_branch);
  endproperty
  a_addlw_dc: assert property (p_addlw_dc) else $error("literal add depends on x bits");

  // cycle accounting
  property p_skip_taken;
    @(posedge clk_i) disable iff (!rstn_i)
      (exec_o && last_phase && fields_reg.is_skip && test_true_i) |=> flush_o;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("taken skip lacked flush");

  property p_extra_sample;
    @(posedge clk_i) disable iff (!rstn_i)
      (exec_o && last_phase && fields_reg.is_skip && !fields_reg.is_branch && !test_true_i)
      |=> insn_take_o;
  endproperty
  a_extra_sample: assert property (p_extra_sample) else $error("untaken skip cost a cycle");

  property p_flush_return;
    @(posedge clk_i) disable iff (!rstn_i)
      (flush_o && last_phase) |=> insn_take_o;
  endproperty
  a_flush_return: assert property (p_flush_return) else $error("no take after flush");

  property p_flush_phase;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(flush_o) |-> (phase_reg == 2'h0);
  endproperty
  a_flush_phase: assert property (p_flush_phase) else $error("flush off cycle boundary");

  // phase sequencing and field hold; words outside the take edge never land
  property p_take_gap;
    @(posedge clk_i) disable iff (!rstn_i)
      insn_take_o |=> (!insn_take_o) [*3];
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("take inside a cycle");

  property p_phase_step;
    @(posedge clk_i) disable iff (!rstn_i)
      (phase_reg != 2'h3) |=> (phase_reg == $past(phase_reg) + 2'h1);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase skipped");

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      (!first_phase) |=> $stable(fields_o);
  endproperty
  a_hold: assert property (p_hold) else $error("fields changed mid cycle");

  // reset is checked without the disable so the restart state itself is covered
  property p_reset_state;
    @(posedge clk_i)
      !rstn_i |=> (phase_o == 2'h0 && exec_o && fields_o == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule

// file: sim/testbench.sv
// self-checking bench for the instruction field decoder
// assumes the decoder answers one cycle after each take, four cycles per instruction, eight with a dead cycle
`timescale 1ns/1ps
module testbench;
  import mifd_pkg::*;
  logic               clk_i       = 1'b0;
  logic               rstn_i      = 1'b0;
  logic [INSN_W-1:0]  insn_i      = '0;
  logic               test_true_i = 1'b0;
  mifd_fields_t       fields_o;
  logic [1:0]         phase_o;
  logic               insn_take_o;
  logic               exec_o;
  logic               flush_o;
  int                 failures    = 0;
  int                 n_compared  = 0;
  int                 cycles      = 0;

  // 50 MHz clock, one period per oscillator period
  always #10 clk_i = ~clk_i;

  mifd_decoder #(.PHASE_CNT(PHASES)) mifd_decoder_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .insn_i(insn_i), .test_true_i(test_true_i),
    .fields_o(fields_o), .phase_o(phase_o), .insn_take_o(insn_take_o),
    .exec_o(exec_o), .flush_o(flush_o));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang costs at most this many cycles; the whole run needs well under 600
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end

  // expected decode, worked out from the field layout alone
  function automatic mifd_fields_t expect_of(input logic [13:0] w);
    mifd_fields_t f;
    f.cls = w[13] ? MIFD_CLASS_LIT : (w[12] ? MIFD_CLASS_BIT : MIFD_CLASS_BYTE);
    f.dest_file = (w[13:12] == 2'h0) && w[7];
    f.file_addr = w[6:0];
    f.bit_num = w[9:7];
    f.lit8 = w[7:0];
    f.lit11 = w[10:0];
    f.is_skip = (w[13:12] == 2'h0 && (w[11:8] == 4'hb || w[11:8] == 4'hf)) ||
                (w[13:12] == 2'h1 && w[11]);
    f.is_branch = w[13:12] == 2'h2 || w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'hd;
    return f;
  endfunction

  // one instruction: wait for take, check fields, phases and the optional dead cycle
  task automatic run_insn(input logic [13:0] w, input logic t);
    mifd_fields_t e;
    logic         fl;
    int           n;
    e = expect_of(w);
    fl = e.is_branch || (e.is_skip && t);
    n = 0;
    while (insn_take_o !== 1'b1 && n < 16) begin
      @(negedge clk_i);
      n++;
    end
    insn_i = w;
    test_true_i = t;
    for (int k = 1; k <= 4; k++) begin
      @(negedge clk_i);
      // a fresh word away from the take edge must be refused
      if (k == 1) insn_i = ~w;
      check("phase", phase_o, k % 4);
      check("fields", fields_o, e);
      check("exec", exec_o, k < 4 || !fl);
      check("take", insn_take_o, k == 4 && !fl);
    end
    check("flush", flush_o, fl);
    if (fl) begin
      @(negedge clk_i);
      check("idle fields", fields_o, '0);
      check("idle exec", exec_o, 1'b0);
      check("idle flush", flush_o, 1'b1);
      repeat (3) @(negedge clk_i);
      check("idle phase", phase_o, 2'h0);
      check("take after idle", insn_take_o, 1'b1);
    end
  endtask

  // destination, address bounds, skips taken and not, test ignored on plain ops
  task automatic t_byte;
    run_insn(14'h07ff, 1'b0);
    run_insn(14'h0700, 1'b0);
    run_insn(14'h0a00, 1'b1);
    run_insn(14'h0b25, 1'b0);
    run_insn(14'h0ba5, 1'b1);
    run_insn(14'h0f10, 1'b1);
  endtask

  // every bit number, skip on odd ones; bit clear never skips
  task automatic t_bit;
    for (int b = 0; b < 8; b++) run_insn(14'h1c7f | 14'(b << 7), b[0]);
    run_insn(14'h1000, 1'b1);
  endtask

  // long and short literals, returns, don't-care bits set both ways on the literal return and move
  task automatic t_lit;
    run_insn(14'h2fff, 1'b0);
    run_insn(14'h2000, 1'b0);
    run_insn(14'h0008, 1'b0);
    run_insn(14'h0009, 1'b0);
    run_insn(14'h37a5, 1'b0);
    run_insn(14'h34a5, 1'b0);
    run_insn(14'h3055, 1'b1);
    run_insn(14'h3355, 1'b1);
    run_insn(14'h3f01, 1'b0);
  endtask

  // reset inside the idle cycle of a branch restarts at phase 0 with cleared fields
  task automatic t_reset;
    insn_i = 14'h2abc;
    repeat (5) @(negedge clk_i);
    check("pre-reset flush", flush_o, 1'b1);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("rst phase", phase_o, 2'h0);
    check("rst take", insn_take_o, 1'b1);
    check("rst flush", flush_o, 1'b0);
    check("rst fields", fields_o, '0);
    rstn_i = 1'b1;
    run_insn(14'h0b7f, 1'b1);
  endtask

  initial begin
    repeat (8) @(negedge clk_i);
    rstn_i = 1'b1;
    t_byte();
    t_bit();
    t_lit();
    t_reset();
    complete_run();
  end
endmodule
